// [rtl/fpa_arbiter.sv]
// Fixed priority arbiter with watchdog and no-response report
`timescale 1ns/1ps
`include "fpa_cfg.svh"
module fpa_arbiter #(
    parameter int WDOG_CYC = `FPA_WDOG_CYC
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [2:0] node_identifier_in,
    input wire logic req_in,
    input wire logic done_in,
    input wire logic tgt_resp_in,
    input wire logic bus_free_in,
    input wire logic bus_reset_in,
    input wire logic sel_line_in,
    input wire fpa_pkg::fpa_lines_type data_lines_in,
    output logic bus_occupied_line_oe_out,
    output logic sel_line_oe_out,
    output fpa_pkg::fpa_lines_type data_lines_oe_out,
    output logic won_out,
    output logic lost_out,
    output logic cmpl_out,
    output logic [1:0] cmpl_status_out
);
    import fpa_pkg::*;
    fpa_state_type state_q, state_d;
    fpa_tmr_if tm();
    fpa_tmr_if wd();
    fpa_timer u_tm (.clk_in(clk_in), .nrst_in(nrst_in), .t(tm.tmr));
    fpa_timer u_wd (.clk_in(clk_in), .nrst_in(nrst_in), .t(wd.tmr));
    localparam logic [16:0] FREE_C = 17'(`FPA_FREE_CYC);
    localparam logic [16:0] LATE_C = 17'(`FPA_LATE_CYC);
    localparam logic [16:0] SAMP_C = 17'(`FPA_SAMPLE_CYC);
    localparam logic [16:0] HOLD_C = 17'(`FPA_HOLD_CYC);
    localparam logic [16:0] WDOG_C = 17'(WDOG_CYC);
    // Longest average start delay a slow target may add to its timeout
    localparam logic [16:0] TGT_C = 17'(`FPA_TGT_CYC);
    // Lines above our own identifier
    fpa_lines_type higher_mask;
    genvar gi;
    generate
        for (gi = 0; gi < `FPA_NODES; gi++) begin : g_hi
            assign higher_mask[gi] = (gi > node_identifier_in);
        end
    endgenerate
    wire higher_seen = |(data_lines_in & higher_mask);
    wire free_ok = tm.count >= FREE_C;
    wire too_late = tm.count > LATE_C;
    wire sample_now = tm.count >= SAMP_C;
    wire hold_done = tm.count >= HOLD_C;
    wire wd_exp = wd.count >= WDOG_C;
    wire lose = higher_seen || sel_line_in;
    wire fail = wd_exp || bus_reset_in;
    wire drive_arb = state_d == FPA_ARB;
    wire drive_sel = state_d == FPA_WON || state_d == FPA_CONN;
    fpa_lines_type id_onehot;
    assign id_onehot = fpa_lines_type'(8'h01 << node_identifier_in);
    always_comb begin
        state_d = state_q;
        case (state_q)
            FPA_IDLE: begin
                if (req_in) state_d = FPA_WAIT_FREE;
            end
            FPA_WAIT_FREE: begin
                if (bus_free_in) state_d = FPA_DELAY;
            end
            FPA_DELAY: begin
                if (!bus_free_in) state_d = FPA_WAIT_FREE;
                else if (free_ok && !too_late) state_d = FPA_ARB;
                else if (too_late) state_d = FPA_DELAY;
            end
            FPA_ARB: begin
                // Another node already selected: back off at once
                if (sel_line_in) state_d = FPA_WAIT_FREE;
                else if (sample_now) begin
                    if (lose) state_d = FPA_WAIT_FREE;
                    else state_d = FPA_WON;
                end
            end
            FPA_WON: begin
                if (hold_done) state_d = FPA_CONN;
            end
            FPA_CONN: begin
                if (fail || done_in) state_d = FPA_IDLE;
            end
            default: state_d = FPA_IDLE;
        endcase
        if (bus_reset_in) state_d = FPA_IDLE;
    end
    // Restart timer on each state change; while free and late, the
    // free detection is refreshed so arbitration waits for new free.
    assign tm.clr = (state_d != state_q) ||
        (state_q == FPA_DELAY && too_late);
    assign tm.run = 1'b1;
    assign wd.clr = state_q != FPA_CONN;
    assign wd.run = !tgt_resp_in;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= FPA_IDLE;
            bus_occupied_line_oe_out <= 1'b1;
            sel_line_oe_out <= 1'b1;
            data_lines_oe_out <= 8'hff;
            won_out <= 1'b0;
            lost_out <= 1'b0;
            cmpl_out <= 1'b0;
            cmpl_status_out <= 2'h0;
        end else begin
            state_q <= state_d;
            bus_occupied_line_oe_out <= !(drive_arb || drive_sel);
            data_lines_oe_out <= (drive_arb || drive_sel) ?
                ~id_onehot : 8'hff;
            sel_line_oe_out <= !drive_sel;
            won_out <= state_q == FPA_ARB && state_d == FPA_WON;
            lost_out <= state_q == FPA_ARB && state_d == FPA_WAIT_FREE;
            cmpl_out <= state_q == FPA_CONN && state_d == FPA_IDLE;
            cmpl_status_out <= fail ? `FPA_STAT_NORSP : `FPA_STAT_OK;
        end
    end
    property p_late;
        @(posedge clk_in) disable iff (!nrst_in)
        (state_q == FPA_DELAY && state_d == FPA_ARB) |-> tm.count <= LATE_C;
    endproperty
    a_late: assert property (p_late) else $error("late arbitration");
    property p_free;
        @(posedge clk_in) disable iff (!nrst_in)
        (state_q == FPA_DELAY && state_d == FPA_ARB) |-> free_ok;
    endproperty
    a_free: assert property (p_free) else $error("early drive");
    property p_lose;
        @(posedge clk_in) disable iff (!nrst_in)
        (state_q == FPA_ARB && sample_now && lose && !bus_reset_in)
        |=> state_q == FPA_WAIT_FREE ##1 bus_occupied_line_oe_out;
    endproperty
    a_lose: assert property (p_lose) else $error("no release");
    property p_win;
        @(posedge clk_in) disable iff (!nrst_in)
        (state_q == FPA_ARB && sample_now && !lose && !bus_reset_in &&
        !sel_line_in) |=> !sel_line_oe_out && won_out;
    endproperty
    a_win: assert property (p_win) else $error("no select");
    property p_hold;
        @(posedge clk_in) disable iff (!nrst_in || bus_reset_in)
        $rose(state_q == FPA_WON) && !bus_reset_in |->
        (state_q == FPA_WON) [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("hold broken");
    property p_norsp;
        @(posedge clk_in) disable iff (!nrst_in)
        (state_q == FPA_CONN && fail) |=> cmpl_out &&
        cmpl_status_out == `FPA_STAT_NORSP;
    endproperty
    a_norsp: assert property (p_norsp) else $error("bad status");
    property p_samp;
        @(posedge clk_in) disable iff (!nrst_in)
        (state_q == FPA_ARB && state_d == FPA_WON) |-> tm.count >= SAMP_C;
    endproperty
    a_samp: assert property (p_samp) else $error("early sample");
    property p_wait;
        @(posedge clk_in) disable iff (!nrst_in)
        (state_q == FPA_WAIT_FREE && !bus_free_in) |=>
        state_q != FPA_ARB;
    endproperty
    a_wait: assert property (p_wait) else $error("no free wait");
    property p_quiet;
        @(posedge clk_in) disable iff (!nrst_in)
        (state_q == FPA_WAIT_FREE || state_q == FPA_DELAY) |->
        bus_occupied_line_oe_out && sel_line_oe_out &&
        data_lines_oe_out == 8'hff;
    endproperty
    a_quiet: assert property (p_quiet) else $error("early drive");
    property p_drive;
        @(posedge clk_in) disable iff (!nrst_in)
        (state_q == FPA_ARB) |-> !bus_occupied_line_oe_out &&
        data_lines_oe_out == ~id_onehot;
    endproperty
    a_drive: assert property (p_drive) else $error("bad arb lines");
    property p_release;
        @(posedge clk_in) disable iff (!nrst_in)
        (state_q == FPA_ARB && sel_line_in) |=>
        bus_occupied_line_oe_out && data_lines_oe_out == 8'hff;
    endproperty
    a_release: assert property (p_release) else $error("slow release");
    property p_hold_len;
        @(posedge clk_in) disable iff (!nrst_in)
        (state_q == FPA_WON && state_d == FPA_CONN) |-> tm.count >= HOLD_C;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("short hold");
    property p_wdog;
        @(posedge clk_in) disable iff (!nrst_in)
        (state_q == FPA_CONN && wd_exp) |=> state_q == FPA_IDLE;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog ignored");
    property p_busrst;
        @(posedge clk_in) disable iff (!nrst_in)
        bus_reset_in |=> state_q == FPA_IDLE;
    endproperty
    a_busrst: assert property (p_busrst) else $error("reset ignored");
    c_win: cover property (@(posedge clk_in) won_out);
    c_lost: cover property (@(posedge clk_in) lost_out);
    c_norsp: cover property (@(posedge clk_in)
        cmpl_out && cmpl_status_out == `FPA_STAT_NORSP);
    c_slow_tgt: cover property (@(posedge clk_in)
        state_q == FPA_CONN && wd.count >= TGT_C);
endmodule

// [rtl/fpa_cfg.svh]
// Constants for the fixed priority bus arbiter
// What this block does
// - Wait for bus free before arbitrating
// - Delay 800 ns after bus free
// - Assert busy and own identifier line
// - No arbitration start beyond 1400 ns
// - No upper wait bound while bus free
// - Sample bus 2200 ns after busy
// - Higher identifier or select means lost
// - Winner asserts the select line
// - Losers release within 800 ns of select
// - Winner holds signals 1200 ns after select
// - Watchdog detects selection response failure
// - Watchdog or reset reports no response
// - Target timeout start delay averages 200us
`ifndef FPA_CFG_SVH
`define FPA_CFG_SVH
`define FPA_CLK_PERIOD_NS 8
`define FPA_FREE_DELAY_NS 800
`define FPA_ARB_LATE_NS 1400
`define FPA_SAMPLE_NS 2200
`define FPA_RELEASE_NS 800
`define FPA_HOLD_NS 1200
`define FPA_TGT_DELAY_US 200
`define FPA_FREE_CYC ((`FPA_FREE_DELAY_NS+`FPA_CLK_PERIOD_NS-1)/`FPA_CLK_PERIOD_NS)
`define FPA_LATE_CYC (`FPA_ARB_LATE_NS/`FPA_CLK_PERIOD_NS)
`define FPA_SAMPLE_CYC ((`FPA_SAMPLE_NS+`FPA_CLK_PERIOD_NS-1)/`FPA_CLK_PERIOD_NS)
`define FPA_RELEASE_CYC (`FPA_RELEASE_NS/`FPA_CLK_PERIOD_NS)
`define FPA_HOLD_CYC ((`FPA_HOLD_NS+`FPA_CLK_PERIOD_NS-1)/`FPA_CLK_PERIOD_NS)
`define FPA_TGT_CYC ((`FPA_TGT_DELAY_US*1000)/`FPA_CLK_PERIOD_NS)
`define FPA_WDOG_CYC 100000
`define FPA_CNT_W 17
`define FPA_ID_W 3
`define FPA_NODES 8
`define FPA_STAT_W 2
`define FPA_STAT_OK 2'h1
`define FPA_STAT_NORSP 2'h2
`endif

// [rtl/fpa_pkg.sv]
// Types for the fixed priority bus arbiter
package fpa_pkg;
    typedef enum logic [5:0] {
        FPA_IDLE = 6'h01,
        FPA_WAIT_FREE = 6'h02,
        FPA_DELAY = 6'h04,
        FPA_ARB = 6'h08,
        FPA_WON = 6'h10,
        FPA_CONN = 6'h20
    } fpa_state_type;
    typedef logic [7:0] fpa_lines_type;
endpackage

// [rtl/fpa_tmr_if.sv]
// Timer carrier between arbiter and its counters
`timescale 1ns/1ps
interface fpa_tmr_if;
    logic clr;
    logic run;
    logic [16:0] count;
    modport ctl(output clr, output run, input count);
    modport tmr(input clr, input run, output count);
endinterface

// [rtl/fpa_timer.sv]
// Saturating cycle counter used for every arbitration delay
`timescale 1ns/1ps
module fpa_timer (
    input wire logic clk_in,
    input wire logic nrst_in,
    fpa_tmr_if.tmr t
);
    logic [16:0] cnt_q;
    logic [16:0] cnt_d;
    assign cnt_d = t.clr ? 17'h00000 :
        ((t.run && cnt_q != 17'h1ffff) ? cnt_q + 17'h00001 : cnt_q);
    assign t.count = cnt_q;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q <= 17'h00000;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// [test/fpa_peer.sv]
// Other nodes on the shared bus, with wired-or line resolution
`timescale 1ns/1ps
module fpa_peer (
    input wire logic busy_oe_in,
    input wire logic sel_oe_in,
    input wire logic [7:0] id_oe_in,
    input wire logic [7:0] peer_ids_in,
    input wire logic peer_sel_in,
    input wire logic peer_hold_in,
    output logic bus_free_out,
    output logic sel_out,
    output logic [7:0] ids_out
);
    // A line reads asserted while any party drives it
    assign ids_out = ~id_oe_in | peer_ids_in;
    assign sel_out = ~sel_oe_in | peer_sel_in;
    assign bus_free_out = busy_oe_in & sel_oe_in & ~peer_hold_in
        & ~|peer_ids_in & ~peer_sel_in;
endmodule

// [test/fpa_arbiter_bench.sv]
// Self-checking bench for the fixed priority arbiter
`timescale 1ns/1ps
module fpa_arbiter_bench;
    import fpa_pkg::*;
    logic clk_in = 0, nrst_in = 0, req = 0, done = 0, resp = 0;
    logic brst = 0, psel = 0, phold = 1, free, sel, busy_oe, sel_oe;
    logic won, lost, cmpl;
    logic [1:0] st;
    logic [2:0] id = 3'h0;
    fpa_lines_type pids = 8'h00, ids, ids_oe, exp_oe;
    int bad_count = 0, n_checks = 0, seed = 32'h35263899;
    fpa_arbiter #(.WDOG_CYC(200)) fpa_arbiter_inst (.clk_in(clk_in),
        .nrst_in(nrst_in), .node_identifier_in(id), .req_in(req),
        .done_in(done), .tgt_resp_in(resp), .bus_free_in(free),
        .bus_reset_in(brst), .sel_line_in(sel), .data_lines_in(ids),
        .bus_occupied_line_oe_out(busy_oe), .sel_line_oe_out(sel_oe),
        .data_lines_oe_out(ids_oe), .won_out(won), .lost_out(lost),
        .cmpl_out(cmpl), .cmpl_status_out(st));
    fpa_peer fpa_peer_inst (.busy_oe_in(busy_oe), .sel_oe_in(sel_oe),
        .id_oe_in(ids_oe), .peer_ids_in(pids), .peer_sel_in(psel),
        .peer_hold_in(phold), .bus_free_out(free), .sel_out(sel),
        .ids_out(ids));
    initial forever #4 clk_in = ~clk_in;
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_in);
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return busy_oe === 1'b0;
            1: return won === 1'b1;
            2: return lost === 1'b1;
            default: return cmpl === 1'b1;
        endcase
    endfunction
    // Bounded wait; c returns the cycles spent
    task automatic wait_for(input int k, lim, output int c);
        for (c = 0; c < lim; c++) begin
            if (pick(k))
                return;
            cyc(1);
        end
        bad_count++;
        $display("Error %0t: wait %0d timed out", $time, k);
        print_verdict;
    endtask
    // Modes: 0 done, 1 higher id, 2 select seen, 3 watchdog, 4 bus reset
    task automatic arb(input int mode);
        int c;
        logic ok;
        nrst_in = 0;
        cyc(3);
        nrst_in = 1;
        id = 3'($unsigned($random(seed)) % 7);
        exp_oe = ~(8'h01 << id);
        resp = (mode != 3);
        req = 1;
        phold = 1;
        cyc(40);
        chk(busy_oe, 1, "busy before free");
        phold = 0;
        wait_for(0, 200, c);
        chk(c >= 100 && c <= 175, 1, "free to busy");
        chk(ids_oe, exp_oe, "id lines");
        // Winners see random lower ids on the bus, which must not matter
        pids = (mode == 1) ? 8'h80 :
            (mode == 2) ? 8'h00 : 8'($random(seed)) & ~(8'hff << id);
        psel = (mode == 2);
        wait_for((mode == 1 || mode == 2) ? 2 : 1, 300, c);
        if (mode == 2)
            chk(c <= 100, 1, "select release");
        else
            chk(c >= 275 && c <= 285, 1, "sample time");
        if (mode == 1 || mode == 2) begin
            cyc(2);
            chk({busy_oe, sel_oe, ids_oe}, 10'h3ff, "release");
        end else begin
            cyc(1);
            chk(sel_oe, 0, "select");
            ok = 1;
            repeat (150) begin
                ok &= (sel_oe === 1'b0 && busy_oe === 1'b0);
                ok &= (ids_oe === exp_oe);
                cyc(1);
            end
            chk(ok, 1, "hold");
            done = (mode == 0);
            brst = (mode == 4);
            cyc(1);
            done = 0;
            wait_for(3, 400, c);
            chk(st, (mode == 0) ? 2'h1 : 2'h2, "status");
            brst = 0;
            cyc(2);
            chk({busy_oe, sel_oe, ids_oe}, 10'h3ff, "idle lines");
        end
        {req, pids, psel} = 0;
        $display("Test mode %0d id %0d done", mode, id);
    endtask
    initial begin
        repeat (2)
            for (int m = 0; m < 5; m++)
                arb(m);
        print_verdict;
    end
endmodule
